/* hw/chc_params.svh */
// Constants for the charger configuration register block
`ifndef CHC_PARAMS_SVH
`define CHC_PARAMS_SVH

`define CHC_CLK_HZ 20000000
`define CHC_ADDR_W 8
`define CHC_DATA_W 8
`define CHC_ADDR_VCTRL 8'h01
`define CHC_ADDR_ICTRL 8'h02
`define CHC_ADDR_NTC 8'h03

`define CHC_RST_VCTRL 8'h23
`define CHC_RST_ICTRL 8'h00
`define CHC_RST_NTC 3'h7
`define CHC_ICTRL_WMASK 8'hef
`define CHC_NTC_W 3

`define CHC_VEOC_MSB 5
`define CHC_VMIN_MSB 7
`define CHC_VMIN_LSB 6
`define CHC_VEOC_MAX_CODE 6'h2f
`define CHC_VEOC_BASE_MV 3500
`define CHC_VEOC_STEP_MV 20
`define CHC_MV_W 13

`define CHC_EOCHALF_BIT 0
`define CHC_CC_MSB 2
`define CHC_CC_LSB 1
`define CHC_BOOSTLO_BIT 3
`define CHC_RSVD_BIT 4
`define CHC_PON_BIT 5
`define CHC_DEB_MSB 7
`define CHC_DEB_LSB 6

`define CHC_NTC_ON_BIT 0
`define CHC_THERM_SEL_BIT 1
`define CHC_NTC_LOW_BIT 2

`define CHC_PCT_W 7
`define CHC_CC_PCT_0 7'h64
`define CHC_CC_PCT_1 7'h51
`define CHC_CC_PCT_2 7'h3c
`define CHC_CC_PCT_3 7'h28
`define CHC_MA_W 10
`define CHC_BOOST_HI_MA 10'h1f4
`define CHC_BOOST_LO_MA 10'h0c8

`define CHC_DEB_LONG_MS 30
`define CHC_DEB_SHORT_MS 3
`define CHC_DEB_LONG_CYC ((`CHC_DEB_LONG_MS * `CHC_CLK_HZ) / 1000)
`define CHC_DEB_SHORT_CYC ((`CHC_DEB_SHORT_MS * `CHC_CLK_HZ) / 1000)
`define CHC_DEB_CNT_W 20

`endif

/* hw/chc_pkg.sv */
// Types shared by the charger configuration register block
package chc_pkg;
  typedef enum logic [1:0] {
    CHC_DEB_30MS,
    CHC_DEB_3MS,
    CHC_DEB_RSVD2,
    CHC_DEB_RSVD3
  } chc_deb_sel_t;
endpackage

/* hw/chc_debounce.sv */
// Comparator debounce filter with selectable interval
`timescale 1ns/1ps
`include "chc_params.svh"
module chc_debounce import chc_pkg::*; #(
  parameter int unsigned LONG_CYC = `CHC_DEB_LONG_CYC,
  parameter int unsigned SHORT_CYC = `CHC_DEB_SHORT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic raw_in,
  input wire chc_deb_sel_t sel,
  output logic filt_q
);
  logic [`CHC_DEB_CNT_W-1:0] cnt_q;
  logic [`CHC_DEB_CNT_W-1:0] limit;

  // Undefined codes fall back to the long interval
  assign limit = (sel == CHC_DEB_3MS) ? `CHC_DEB_CNT_W'(SHORT_CYC - 1)
                                      : `CHC_DEB_CNT_W'(LONG_CYC - 1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (raw_in == filt_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= limit) begin
      cnt_q <= '0;
      filt_q <= raw_in;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  property p_deb_hold;
    @(posedge ref_clk) disable iff (rst)
    (filt_q != $past(filt_q)) |-> ($past(cnt_q) >= $past(limit)) && ($past(raw_in) == filt_q);
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("filter changed early");
endmodule

/* hw/chc_config_regs.sv */
// Charger configuration registers: voltage, current and thermistor control
// Operation
// - Six-bit end-of-charge code: 0 is 3.5 V, 35 is 4.2 V, 47 is 4.44 V
// - Two-bit minimum input level; current reduced while input supply is below it
// - Termination current full or half
// - Constant-current scale: full, 0.81, 0.60 or 0.40
// - Boost current limit 500 mA, or 200 mA when bit set
// - Full high-side on mode when set; otherwise smooth mode only with off-time disable
// - Debounce 30 ms for code 0, 3 ms for code 1; others undefined
// - Battery temperature supervision off at 0, on at 1
// - Thermistor nominal value 100k at 0, 10k at 1
// - Shutdown range high at 0, low at 1
// - Off-time disable lets the charger move smoothly into full conduction
// - Over-temperature flag set above threshold, evaluated only with input detected
`timescale 1ns/1ps
`include "chc_params.svh"
module chc_config_regs import chc_pkg::*; #(
  parameter int unsigned DEB_LONG_CYC = `CHC_DEB_LONG_CYC,
  parameter int unsigned DEB_SHORT_CYC = `CHC_DEB_SHORT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [`CHC_ADDR_W-1:0] reg_addr,
  input wire logic [`CHC_DATA_W-1:0] reg_wdata,
  output logic [`CHC_DATA_W-1:0] reg_rdata_q,
  input wire logic [`CHC_DATA_W-1:0] otp_vctrl,
  input wire logic [`CHC_DATA_W-1:0] otp_ictrl,
  input wire logic [`CHC_NTC_W-1:0] otp_ntc,
  input wire logic [3:0] input_supply_below,
  input wire logic input_supply_detect,
  input wire logic disable_toff,
  input wire logic temp_above_high_range,
  input wire logic temp_above_low_range,
  output logic [`CHC_MV_W-1:0] eoc_voltage_mv_q,
  output logic current_reduce_q,
  output logic term_half_q,
  output logic [`CHC_PCT_W-1:0] cc_scale_pct_q,
  output logic [`CHC_MA_W-1:0] boost_limit_ma_q,
  output logic pmos_full_on_q,
  output logic pmos_smooth_q,
  output logic ntc_supervision_on_q,
  output logic thermistor_value_select_q,
  output logic ntc_low_range_q,
  output logic battery_overtemp_flag_q
);
  logic load_pend_q;
  logic [`CHC_DATA_W-1:0] vctrl_q;
  logic [`CHC_DATA_W-1:0] ictrl_q;
  logic [`CHC_NTC_W-1:0] ntc_q;
  logic [`CHC_DATA_W-1:0] rd_mux;
  logic [5:0] veoc_clamp;
  logic temp_raw;
  logic temp_filt;
  chc_deb_sel_t deb_sel;

  // Defaults come from OTP on the first edge after reset release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_pend_q <= 1'b1;
    end else begin
      load_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vctrl_q <= `CHC_RST_VCTRL;
    end else if (load_pend_q) begin
      vctrl_q <= otp_vctrl;
    end else if (reg_wr_en && reg_addr == `CHC_ADDR_VCTRL) begin
      vctrl_q <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ictrl_q <= `CHC_RST_ICTRL;
    end else if (load_pend_q) begin
      ictrl_q <= otp_ictrl & `CHC_ICTRL_WMASK;
    end else if (reg_wr_en && reg_addr == `CHC_ADDR_ICTRL) begin
      ictrl_q <= reg_wdata & `CHC_ICTRL_WMASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ntc_q <= `CHC_RST_NTC;
    end else if (load_pend_q) begin
      ntc_q <= otp_ntc;
    end else if (reg_wr_en && reg_addr == `CHC_ADDR_NTC) begin
      ntc_q <= reg_wdata[`CHC_NTC_W-1:0];
    end
  end

  // Read path; unmapped addresses and unused bits read zero
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      `CHC_ADDR_VCTRL: rd_mux = vctrl_q;
      `CHC_ADDR_ICTRL: rd_mux = ictrl_q;
      `CHC_ADDR_NTC: rd_mux = {{(`CHC_DATA_W-`CHC_NTC_W){1'b0}}, ntc_q};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd_en) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // Voltage control decode
  assign veoc_clamp = (vctrl_q[`CHC_VEOC_MSB:0] > `CHC_VEOC_MAX_CODE) ?
                      `CHC_VEOC_MAX_CODE : vctrl_q[`CHC_VEOC_MSB:0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eoc_voltage_mv_q <= '0;
      current_reduce_q <= 1'b0;
    end else begin
      eoc_voltage_mv_q <= `CHC_MV_W'(`CHC_VEOC_BASE_MV +
                          `CHC_VEOC_STEP_MV * int'(veoc_clamp));
      current_reduce_q <= input_supply_below[vctrl_q[`CHC_VMIN_MSB:`CHC_VMIN_LSB]];
    end
  end

  // Current control decode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      term_half_q <= 1'b0;
      cc_scale_pct_q <= '0;
      boost_limit_ma_q <= '0;
    end else begin
      term_half_q <= ictrl_q[`CHC_EOCHALF_BIT];
      unique case (ictrl_q[`CHC_CC_MSB:`CHC_CC_LSB])
        2'h0: cc_scale_pct_q <= `CHC_CC_PCT_0;
        2'h1: cc_scale_pct_q <= `CHC_CC_PCT_1;
        2'h2: cc_scale_pct_q <= `CHC_CC_PCT_2;
        2'h3: cc_scale_pct_q <= `CHC_CC_PCT_3;
      endcase
      boost_limit_ma_q <= ictrl_q[`CHC_BOOSTLO_BIT] ? `CHC_BOOST_LO_MA
                                                    : `CHC_BOOST_HI_MA;
    end
  end

  // High-side conduction mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pmos_full_on_q <= 1'b0;
      pmos_smooth_q <= 1'b0;
    end else begin
      pmos_full_on_q <= ictrl_q[`CHC_PON_BIT];
      pmos_smooth_q <= !ictrl_q[`CHC_PON_BIT] && disable_toff;
    end
  end

  // Thermistor supervision
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ntc_supervision_on_q <= 1'b0;
      thermistor_value_select_q <= 1'b0;
      ntc_low_range_q <= 1'b0;
    end else begin
      ntc_supervision_on_q <= ntc_q[`CHC_NTC_ON_BIT];
      thermistor_value_select_q <= ntc_q[`CHC_THERM_SEL_BIT];
      ntc_low_range_q <= ntc_q[`CHC_NTC_LOW_BIT];
    end
  end

  assign temp_raw = ntc_q[`CHC_NTC_LOW_BIT] ? temp_above_low_range
                                            : temp_above_high_range;
  assign deb_sel = chc_deb_sel_t'(ictrl_q[`CHC_DEB_MSB:`CHC_DEB_LSB]);

  chc_debounce #(
    .LONG_CYC(DEB_LONG_CYC),
    .SHORT_CYC(DEB_SHORT_CYC)
  ) u_temp_deb (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw_in(temp_raw),
    .sel(deb_sel),
    .filt_q(temp_filt)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      battery_overtemp_flag_q <= 1'b0;
    end else begin
      battery_overtemp_flag_q <= temp_filt && input_supply_detect &&
                                 ntc_q[`CHC_NTC_ON_BIT];
    end
  end

  // Checks; attempts on the releasing edge still see reset values, so they are skipped
  property p_eoc_decode;
    @(posedge ref_clk) disable iff (rst)
    !rst && (vctrl_q[`CHC_VEOC_MSB:0] <= `CHC_VEOC_MAX_CODE) |=>
      (eoc_voltage_mv_q == `CHC_MV_W'(`CHC_VEOC_BASE_MV +
       `CHC_VEOC_STEP_MV * int'($past(vctrl_q[`CHC_VEOC_MSB:0]))));
  endproperty
  a_eoc_decode: assert property (p_eoc_decode) else $error("eoc voltage wrong");

  property p_vmin;
    @(posedge ref_clk) disable iff (rst)
    !rst |=> current_reduce_q ==
      $past(input_supply_below[vctrl_q[`CHC_VMIN_MSB:`CHC_VMIN_LSB]]);
  endproperty
  a_vmin: assert property (p_vmin) else $error("current reduce wrong");

  property p_term;
    @(posedge ref_clk) disable iff (rst)
    !rst |=> term_half_q == $past(ictrl_q[`CHC_EOCHALF_BIT]);
  endproperty
  a_term: assert property (p_term) else $error("termination select wrong");

  property p_cc;
    @(posedge ref_clk) disable iff (rst)
    (ictrl_q[`CHC_CC_MSB:`CHC_CC_LSB] == 2'h1) |=> (cc_scale_pct_q == `CHC_CC_PCT_1);
  endproperty
  a_cc: assert property (p_cc) else $error("cc scale wrong");

  property p_boost;
    @(posedge ref_clk) disable iff (rst)
    ictrl_q[`CHC_BOOSTLO_BIT] |=> (boost_limit_ma_q == `CHC_BOOST_LO_MA);
  endproperty
  a_boost: assert property (p_boost) else $error("boost limit wrong");

  property p_pmos;
    @(posedge ref_clk) disable iff (rst)
    !rst |=> !(pmos_full_on_q && pmos_smooth_q) &&
      (pmos_smooth_q == (!$past(ictrl_q[`CHC_PON_BIT]) && $past(disable_toff)));
  endproperty
  a_pmos: assert property (p_pmos) else $error("pmos mode wrong");

  property p_thermval;
    @(posedge ref_clk) disable iff (rst)
    !rst |=> thermistor_value_select_q == $past(ntc_q[`CHC_THERM_SEL_BIT]);
  endproperty
  a_thermval: assert property (p_thermval) else $error("thermistor select wrong");

  property p_flag_gate;
    @(posedge ref_clk) disable iff (rst)
    (!input_supply_detect || !ntc_q[`CHC_NTC_ON_BIT]) |=> !battery_overtemp_flag_q;
  endproperty
  a_flag_gate: assert property (p_flag_gate) else $error("overtemp flag not gated");

  property p_rsvd;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd_en && reg_addr == `CHC_ADDR_ICTRL) |=> !reg_rdata_q[`CHC_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");

  sequence s_wr_vctrl;
    reg_wr_en && !load_pend_q && reg_addr == `CHC_ADDR_VCTRL;
  endsequence
  sequence s_rd_vctrl;
    reg_rd_en && !reg_wr_en && reg_addr == `CHC_ADDR_VCTRL;
  endsequence
  property p_wr_rd;
    @(posedge ref_clk) disable iff (rst)
    s_wr_vctrl ##1 s_rd_vctrl |=> reg_rdata_q == $past(reg_wdata, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback mismatch");
endmodule

/* tb/chc_host.sv */
// Host controller model driving the register strobe port
`timescale 1ns/1ps
`include "chc_params.svh"
module chc_host (
  input wire logic ref_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [`CHC_ADDR_W-1:0] reg_addr,
  output logic [`CHC_DATA_W-1:0] reg_wdata,
  input wire logic [`CHC_DATA_W-1:0] reg_rdata_q
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One-cycle write strobe; data is scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // One-cycle read strobe; data is taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata_q;
  endtask
  // Write strobe, then a read of the same register on the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata_q;
  endtask
endmodule

/* tb/charger_config_registers_tb.sv */
// Self-checking bench for the charger configuration registers
`timescale 1ns/1ps
`include "chc_params.svh"
module charger_config_registers_tb import chc_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr_en, reg_rd_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, v, wd;
  logic [7:0] otp_vctrl = 8'h6f;
  logic [7:0] otp_ictrl = 8'hff;
  logic [2:0] otp_ntc = 3'h5;
  logic [3:0] input_supply_below = 4'h0;
  logic input_supply_detect = 1'b0;
  logic disable_toff = 1'b0;
  logic temp_above_high_range = 1'b0;
  logic temp_above_low_range = 1'b0;
  logic [12:0] eoc_voltage_mv_q;
  logic [6:0] cc_scale_pct_q;
  logic [9:0] boost_limit_ma_q;
  logic current_reduce_q, term_half_q, pmos_full_on_q, pmos_smooth_q;
  logic ntc_supervision_on_q, thermistor_value_select_q, ntc_low_range_q;
  logic battery_overtemp_flag_q;
  logic [1:0] k;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int vc[4] = '{0, 35, 47, 63};
  int vm[4] = '{3500, 4200, 4440, 4440};
  int pc[4] = '{100, 81, 60, 40};
  chc_host uh (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));
  chc_config_regs #(.DEB_LONG_CYC(20), .DEB_SHORT_CYC(4)) uut (.ref_clk(ref_clk), .rst(rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .otp_vctrl(otp_vctrl),
    .otp_ictrl(otp_ictrl), .otp_ntc(otp_ntc), .input_supply_below(input_supply_below),
    .input_supply_detect(input_supply_detect), .disable_toff(disable_toff),
    .temp_above_high_range(temp_above_high_range),
    .temp_above_low_range(temp_above_low_range), .eoc_voltage_mv_q(eoc_voltage_mv_q),
    .current_reduce_q(current_reduce_q), .term_half_q(term_half_q),
    .cc_scale_pct_q(cc_scale_pct_q), .boost_limit_ma_q(boost_limit_ma_q),
    .pmos_full_on_q(pmos_full_on_q), .pmos_smooth_q(pmos_smooth_q),
    .ntc_supervision_on_q(ntc_supervision_on_q),
    .thermistor_value_select_q(thermistor_value_select_q),
    .ntc_low_range_q(ntc_low_range_q), .battery_overtemp_flag_q(battery_overtemp_flag_q));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    uh.rd(a, v);
    chk(16'(v), 16'(e));
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic stop_test;
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    settle(3);
    rchk(8'h01, 8'h6f);
    rchk(8'h02, 8'hef);
    rchk(8'h03, 8'h05);
    chk(16'(eoc_voltage_mv_q), 16'd4440);
    // Voltage codes and minimum input level per code
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      input_supply_below <= 4'h1 << i;
      uh.wr(8'h01, {2'(i), 6'(vc[i])});
      settle(2);
      chk(16'(eoc_voltage_mv_q), 16'(vm[i]));
      chk(16'(current_reduce_q), 16'h1);
      @(posedge ref_clk);
      input_supply_below <= ~(4'h1 << i);
      settle(2);
      chk(16'(current_reduce_q), 16'h0);
    end
    // Current control fields, with bit 4 always written as one
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      wd = {2'b00, k[0], 1'b1, k[1], k, k[0]};
      @(posedge ref_clk);
      disable_toff <= k[1];
      uh.wr(8'h02, wd);
      rchk(8'h02, wd & 8'hef);
      settle(1);
      chk(16'(term_half_q), 16'(k[0]));
      chk(16'(cc_scale_pct_q), 16'(pc[i]));
      chk(16'(boost_limit_ma_q), k[1] ? 16'd200 : 16'd500);
      chk(16'(pmos_full_on_q), 16'(k[0]));
      chk(16'(pmos_smooth_q), 16'(!k[0] && k[1]));
    end
    uh.wr(8'h03, 8'hff);
    rchk(8'h03, 8'h07);
    settle(1);
    chk(16'({ntc_low_range_q, thermistor_value_select_q, ntc_supervision_on_q}), 16'h7);
    uh.wr(8'h03, 8'h00);
    rchk(8'h03, 8'h00);
    settle(2);
    chk(16'({ntc_low_range_q, thermistor_value_select_q, ntc_supervision_on_q}), 16'h0);
    uh.wr(8'h04, 8'h00);
    rchk(8'h04, 8'h00);
    rchk(8'h01, 8'hff);
    // Over-temperature path with low range selected and long debounce
    uh.wr(8'h03, 8'h05);
    uh.wr(8'h02, 8'h00);
    @(posedge ref_clk);
    input_supply_detect <= 1'b1;
    temp_above_high_range <= 1'b1;
    settle(30);
    chk(16'(battery_overtemp_flag_q), 16'h0);
    // Long interval of 20 cycles: filter flips on the 20th edge, flag one edge later
    @(posedge ref_clk);
    temp_above_low_range <= 1'b1;
    settle(20);
    chk(16'(battery_overtemp_flag_q), 16'h0);
    settle(1);
    chk(16'(battery_overtemp_flag_q), 16'h1);
    @(posedge ref_clk);
    input_supply_detect <= 1'b0;
    settle(2);
    chk(16'(battery_overtemp_flag_q), 16'h0);
    @(posedge ref_clk);
    temp_above_low_range <= 1'b0;
    settle(30);
    // Short interval of 4 cycles
    uh.wr(8'h02, 8'h40);
    @(posedge ref_clk);
    input_supply_detect <= 1'b1;
    temp_above_low_range <= 1'b1;
    settle(4);
    chk(16'(battery_overtemp_flag_q), 16'h0);
    settle(1);
    chk(16'(battery_overtemp_flag_q), 16'h1);
    @(posedge ref_clk);
    temp_above_low_range <= 1'b0;
    settle(8);
    // Undefined code 2 falls back to the long interval
    uh.wr(8'h02, 8'h80);
    @(posedge ref_clk);
    temp_above_low_range <= 1'b1;
    settle(20);
    chk(16'(battery_overtemp_flag_q), 16'h0);
    settle(1);
    chk(16'(battery_overtemp_flag_q), 16'h1);
    // Write followed at once by a read of the same register
    uh.wr_rd(8'h01, 8'h5a, v);
    chk(16'(v), 16'h5a);
    settle(1);
    chk(16'(eoc_voltage_mv_q), 16'd4020);
    stop_test;
  end
endmodule
